// >>> inc/char_arith_consts.svh
`ifndef CHAR_ARITH_CONSTS_SVH
`define CHAR_ARITH_CONSTS_SVH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_A_ADDR 8'h04
`define REG_B_ADDR 8'h08
`define REG_STATUS 8'h0c
`define REG_TEST 8'h10

// Field positions
`define CTRL_OP_LSB 0
`define STAT_BUSY_BIT 0
`define STAT_OVF_BIT 1
`define STAT_ZERO_BIT 2
`define TEST_CLR_BIT 0

// Normalized sign zones and responses
`define ZONE_PLUS 2'b01
`define ZONE_MINUS 2'b10
`define ZONE_NONE 2'b00
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// Reset values
`define RST_ADDR 32'h0000_0000

`endif

// >>> inc/char_arith_pkg.sv
`default_nettype none
package char_arith_pkg;
    typedef enum logic [2:0] {
        OP_BIN_ADD,
        OP_BIN_SUB,
        OP_DEC_ADD,
        OP_DEC_SUB,
        OP_DEC_MUL,
        OP_DEC_DIV
    } op_t;

    typedef enum logic [3:0] {
        S_IDLE,
        S_RDA,
        S_RDB,
        S_WRB,
        S_RCRD,
        S_RCWR,
        S_MSCAN,
        S_MCLR,
        S_MRDM,
        S_MZM,
        S_MSGRD,
        S_MSGWR,
        S_DSCAN
    } state_t;
endpackage
`default_nettype wire

// >>> core/char_serial_arith_unit.sv
// Summary of operation
// RQ1 - Add uses B as augend, A as addend, sum into B.
// RQ2 - Subtract uses A as subtrahend, B as minuend, difference into B.
// RQ3 - Binary add sums bits with carry rippling upward.
// RQ4 - Binary subtract adds ones complement of A plus forced first carry.
// RQ5 - Binary subtract stops at B word mark; extra A characters ignored.
// RQ6 - Short A field is padded with complemented zeros.
// RQ7 - Binary subtract drops final carry, no overflow, nothing beyond B.
// RQ8 - Sign comes from units zone bits; plus 01, minus 10.
// RQ9 - Zones 00, 01, 11 mean plus; only 10 means minus.
// RQ10 - Like signs true add; units keeps B zone, other zones cleared.
// RQ11 - Unlike signs tens complement A, add, test final carry.
// RQ12 - Carry out means true result with normalized B sign.
// RQ13 - No carry starts recomplement pass that inverts the sign.
// RQ14 - Decimal subtract inverts A sign, then follows add rules.
// RQ15 - True add carry out sets overflow, otherwise unchanged.
// RQ16 - Zero balance set at start, cleared for nonzero result.
// RQ17 - Zero divisor sets overflow; zero product sets zero balance.
// RQ18 - Condition test clears overflow; zero balance unchanged by it.
// RQ19 - Multiply A by leftmost B multiplier, product right in B.
// RQ20 - Program sizes B as multiplier plus multiplicand plus one.
// RQ21 - Program marks leftmost factor characters only.
// RQ22 - Multiplier units position is B minus A length minus one.
// RQ23 - Product sign plus if signs agree, normalized zones.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "char_arith_consts.svh"

module char_serial_arith_unit #(
    parameter int AW = 16
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Character memory
    output logic mem_req,
    output logic mem_we,
    output logic [AW-1:0] mem_addr,
    output logic [5:0] mem_wdata,
    input wire logic [5:0] mem_rdata,
    input wire logic mem_rmark,
    input wire logic mem_ack
);
    import char_arith_pkg::*;

    state_t state;
    op_t op, start_op;
    logic start, test_clr, aw_have, w_have, busy, ovf, zero_bal, ovf_set;
    logic [7:0] waddr;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [AW-1:0] a_addr, b_addr, a_ptr, b_ptr, a_start, b_start, len, cnt, na, mp_ptr, win;
    logic [5:0] a_char, b_char;
    logic [3:0] mdig;
    logic b_mark, a_done, first, comp, carry, sb, nz, mp_mark, mc_neg, mp_neg, mc_nz, mp_nz;

    function automatic logic [3:0] digit(input logic [5:0] c);
        digit = (c[3:0] >= 4'hc) ? 4'h0 : c[3:0];
    endfunction

    // AXI write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            aw_have <= 1'b0;
            w_have <= 1'b0;
            waddr <= 8'h00;
            wd <= 32'h0000_0000;
            ws <= 4'h0;
            a_addr <= AW'(`RST_ADDR);
            b_addr <= AW'(`RST_ADDR);
            start <= 1'b0;
            start_op <= OP_BIN_ADD;
            test_clr <= 1'b0;
        end else begin
            start <= 1'b0;
            test_clr <= 1'b0;
            awready <= !aw_have && !awready && awvalid;
            wready <= !w_have && !wready && wvalid;
            if (awvalid && awready) begin
                aw_have <= 1'b1;
                waddr <= awaddr;
            end
            if (wvalid && wready) begin
                w_have <= 1'b1;
                wd <= wdata;
                ws <= wstrb;
            end
            if (aw_have && w_have && !bvalid) begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                bvalid <= 1'b1;
                bresp <= `RESP_OKAY;
                unique case ({waddr[7:2], 2'b00})
                    `REG_CTRL: begin
                        if (ws[0] && !busy && wd[2:0] <= 3'h5) begin
                            start <= 1'b1;
                            start_op <= op_t'(wd[`CTRL_OP_LSB +: 3]);
                        end
                    end
                    `REG_A_ADDR: begin
                        for (int i = 0; i < AW; i++) begin
                            if (ws[i/8]) a_addr[i] <= wd[i];
                        end
                    end
                    `REG_B_ADDR: begin
                        for (int i = 0; i < AW; i++) begin
                            if (ws[i/8]) b_addr[i] <= wd[i];
                        end
                    end
                    `REG_STATUS: ;
                    `REG_TEST: test_clr <= ws[0] && wd[`TEST_CLR_BIT]; // RQ18
                    default: bresp <= `RESP_SLVERR;
                endcase
            end
            if (bvalid && bready) bvalid <= 1'b0;
        end
    end

    // AXI read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
        end else begin
            arready <= !rvalid && !arready && arvalid;
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rresp <= `RESP_OKAY;
                rdata <= 32'h0000_0000;
                unique case ({araddr[7:2], 2'b00})
                    `REG_CTRL: rdata[`CTRL_OP_LSB +: 3] <= op;
                    `REG_A_ADDR: rdata[AW-1:0] <= a_addr;
                    `REG_B_ADDR: rdata[AW-1:0] <= b_addr;
                    `REG_STATUS: begin
                        rdata[`STAT_BUSY_BIT] <= busy;
                        rdata[`STAT_OVF_BIT] <= ovf;
                        rdata[`STAT_ZERO_BIT] <= zero_bal;
                    end
                    `REG_TEST: rdata[1:0] <= {zero_bal, ovf};
                    default: rresp <= `RESP_SLVERR;
                endcase
            end
            if (rvalid && rready) rvalid <= 1'b0;
        end
    end

    // Character adder
    logic dec, mul, sa, sbn, cmp, cin, cout, rc_cout;
    logic [3:0] ad, bd, dig, rc_dig;
    logic [4:0] dsum, rsum;
    logic [6:0] bsum;
    logic [5:0] res;
    logic [1:0] uzone;
    always_comb begin
        dec = (op == OP_DEC_ADD) || (op == OP_DEC_SUB);
        mul = (op == OP_DEC_MUL);
        sa = (a_char[5:4] == `ZONE_MINUS) ^ (op == OP_DEC_SUB); // RQ9 RQ14
        sbn = (b_char[5:4] == `ZONE_MINUS); // RQ8 RQ9
        cmp = mul ? 1'b0 : (first ? (sa ^ sbn) : comp); // RQ10 RQ11
        cin = (first && !mul) ? ((op == OP_BIN_SUB) || (dec && cmp)) : carry; // RQ4 RQ11
        bsum = {1'b0, b_char} + {1'b0, (op == OP_BIN_SUB) ? ~a_char : a_char} + {6'h00, cin}; // RQ3 RQ4
        ad = digit(a_char);
        if (cmp) ad = 4'h9 - ad; // RQ11
        bd = digit(b_char);
        dsum = {1'b0, bd} + {1'b0, ad} + {4'h0, cin}; // RQ1 RQ2
        dig = dsum[3:0];
        cout = 1'b0;
        if (dsum > 5'h09) begin
            dig = 4'(dsum - 5'h0a);
            cout = 1'b1;
        end
        uzone = cmp ? (sbn ? `ZONE_MINUS : `ZONE_PLUS) : b_char[5:4]; // RQ10 RQ12
        if (op == OP_BIN_ADD || op == OP_BIN_SUB) begin
            res = bsum[5:0];
            cout = bsum[6];
        end else begin
            res = {(first && dec) ? uzone : `ZONE_NONE, dig}; // RQ10
        end
        rsum = {1'b0, 4'h9 - bd} + {4'h0, carry}; // RQ13
        rc_dig = rsum[3:0];
        rc_cout = 1'b0;
        if (rsum > 5'h09) begin
            rc_dig = 4'(rsum - 5'h0a);
            rc_cout = 1'b1;
        end
        ovf_set = (state == S_WRB && mem_req && mem_ack && dec && b_mark && !cmp && cout) // RQ15
            || (state == S_DSCAN && mem_req && mem_ack && mem_rmark && !nz
                && digit(mem_rdata) == 4'h0); // RQ17
    end

    // Overflow indicator, set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) ovf <= 1'b0;
        else if (ovf_set) ovf <= 1'b1; // RQ15 RQ17
        else if (test_clr) ovf <= 1'b0; // RQ18
    end

    // Sequencer and memory port
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= S_IDLE;
            op <= OP_BIN_ADD;
            busy <= 1'b0;
            zero_bal <= 1'b0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= '0;
            mem_wdata <= 6'h00;
            {a_ptr, b_ptr, a_start, b_start, len, cnt, na, mp_ptr, win} <= '0;
            {a_char, b_char} <= 12'h000;
            mdig <= 4'h0;
            {b_mark, a_done, first, comp, carry, sb, nz} <= 7'h00;
            {mp_mark, mc_neg, mp_neg, mc_nz, mp_nz} <= 5'h00;
        end else begin
            unique case (state)
                S_IDLE: if (start) begin
                    op <= start_op;
                    busy <= 1'b1;
                    {a_ptr, a_start} <= {a_addr, a_addr};
                    {b_ptr, b_start} <= {b_addr, b_addr};
                    {first, a_done, nz, carry} <= 4'h8;
                    {len, cnt, na} <= '0;
                    if (start_op == OP_DEC_ADD || start_op == OP_DEC_SUB) zero_bal <= 1'b1; // RQ16
                    if (start_op == OP_DEC_MUL) state <= S_MSCAN;
                    else if (start_op == OP_DEC_DIV) state <= S_DSCAN;
                    else state <= S_RDA;
                end
                S_RDA: begin
                    if (mul ? (cnt == na) : a_done) begin
                        a_char <= 6'h00; // RQ6
                        state <= S_RDB;
                    end else if (!mem_req) begin
                        {mem_req, mem_we, mem_addr} <= {2'b10, a_ptr};
                    end else if (mem_ack) begin
                        mem_req <= 1'b0;
                        a_char <= mem_rdata;
                        a_done <= mem_rmark;
                        a_ptr <= a_ptr - AW'(1);
                        state <= S_RDB;
                    end
                end
                S_RDB: if (!mem_req) begin
                    {mem_req, mem_we, mem_addr} <= {2'b10, b_ptr};
                end else if (mem_ack) begin
                    mem_req <= 1'b0;
                    b_char <= mem_rdata;
                    b_mark <= mem_rmark;
                    state <= S_WRB;
                end
                S_WRB: if (!mem_req) begin
                    {mem_req, mem_we, mem_addr} <= {2'b11, b_ptr};
                    mem_wdata <= res;
                end else if (mem_ack) begin
                    mem_req <= 1'b0;
                    b_ptr <= b_ptr - AW'(1);
                    first <= 1'b0;
                    if (first) {comp, sb} <= {cmp, sbn};
                    carry <= cout;
                    len <= len + AW'(1);
                    nz <= nz || (dig != 4'h0);
                    if (mul) begin
                        cnt <= cnt + AW'(1);
                        if (cnt == na) begin
                            mdig <= mdig - 4'h1;
                            if (mdig != 4'h1) begin
                                {cnt, a_ptr, b_ptr, carry} <= {AW'(0), a_start, win, 1'b0};
                                state <= S_RDA;
                            end else if (!mp_mark) begin
                                {mp_ptr, win} <= {mp_ptr - AW'(1), win - AW'(1)};
                                state <= S_MRDM;
                            end else begin
                                state <= S_MSGRD;
                            end
                        end else begin
                            state <= S_RDA;
                        end
                    end else if (b_mark) begin // RQ5 RQ7
                        if (dec && cmp && !cout) begin // RQ13
                            {b_ptr, cnt, carry, nz, first} <= {b_start, AW'(0), 3'b101};
                            state <= S_RCRD;
                        end else begin
                            if (dec) zero_bal <= !(nz || (dig != 4'h0)); // RQ16
                            busy <= 1'b0;
                            state <= S_IDLE;
                        end
                    end else begin
                        state <= S_RDA;
                    end
                end
                S_RCRD: if (!mem_req) begin
                    {mem_req, mem_we, mem_addr} <= {2'b10, b_ptr};
                end else if (mem_ack) begin
                    mem_req <= 1'b0;
                    b_char <= mem_rdata;
                    state <= S_RCWR;
                end
                S_RCWR: if (!mem_req) begin
                    {mem_req, mem_we, mem_addr} <= {2'b11, b_ptr};
                    mem_wdata <= {first ? (sb ? `ZONE_PLUS : `ZONE_MINUS) : `ZONE_NONE, rc_dig}; // RQ13
                end else if (mem_ack) begin
                    mem_req <= 1'b0;
                    {first, carry} <= {1'b0, rc_cout};
                    nz <= nz || (rc_dig != 4'h0);
                    b_ptr <= b_ptr - AW'(1);
                    cnt <= cnt + AW'(1);
                    if (cnt == len - AW'(1)) begin
                        zero_bal <= !(nz || (rc_dig != 4'h0)); // RQ16
                        busy <= 1'b0;
                        state <= S_IDLE;
                    end else begin
                        state <= S_RCRD;
                    end
                end
                S_MSCAN: if (!mem_req) begin
                    {mem_req, mem_we, mem_addr} <= {2'b10, a_ptr};
                end else if (mem_ack) begin
                    mem_req <= 1'b0;
                    na <= na + AW'(1);
                    a_ptr <= a_ptr - AW'(1);
                    first <= 1'b0;
                    if (first) mc_neg <= (mem_rdata[5:4] == `ZONE_MINUS);
                    mc_nz <= (first ? 1'b0 : mc_nz) || (digit(mem_rdata) != 4'h0);
                    if (mem_rmark) begin
                        {b_ptr, cnt} <= {b_start, AW'(0)};
                        state <= S_MCLR;
                    end
                end
                S_MCLR: if (!mem_req) begin
                    {mem_req, mem_we, mem_addr} <= {2'b11, b_ptr};
                    mem_wdata <= 6'h00;
                end else if (mem_ack) begin
                    mem_req <= 1'b0;
                    b_ptr <= b_ptr - AW'(1);
                    cnt <= cnt + AW'(1);
                    if (cnt == na) begin
                        mp_ptr <= b_start - na - AW'(1); // RQ22
                        {win, first, mp_nz} <= {b_start, 2'b10};
                        state <= S_MRDM;
                    end
                end
                S_MRDM: if (!mem_req) begin
                    {mem_req, mem_we, mem_addr} <= {2'b10, mp_ptr};
                end else if (mem_ack) begin
                    mem_req <= 1'b0;
                    mdig <= digit(mem_rdata);
                    mp_mark <= mem_rmark;
                    if (first) mp_neg <= (mem_rdata[5:4] == `ZONE_MINUS);
                    mp_nz <= mp_nz || (digit(mem_rdata) != 4'h0);
                    state <= S_MZM;
                end
                S_MZM: if (!mem_req) begin
                    {mem_req, mem_we, mem_addr} <= {2'b11, mp_ptr};
                    mem_wdata <= 6'h00;
                end else if (mem_ack) begin
                    mem_req <= 1'b0;
                    first <= 1'b0;
                    if (mdig != 4'h0) begin // RQ19
                        {cnt, a_ptr, b_ptr, carry} <= {AW'(0), a_start, win, 1'b0};
                        state <= S_RDA;
                    end else if (!mp_mark) begin
                        {mp_ptr, win} <= {mp_ptr - AW'(1), win - AW'(1)};
                        state <= S_MRDM;
                    end else begin
                        state <= S_MSGRD;
                    end
                end
                S_MSGRD: if (!mem_req) begin
                    {mem_req, mem_we, mem_addr} <= {2'b10, b_start};
                end else if (mem_ack) begin
                    mem_req <= 1'b0;
                    b_char <= mem_rdata;
                    state <= S_MSGWR;
                end
                S_MSGWR: if (!mem_req) begin
                    {mem_req, mem_we, mem_addr} <= {2'b11, b_start};
                    mem_wdata <= {(mc_neg ^ mp_neg) ? `ZONE_MINUS : `ZONE_PLUS, b_char[3:0]}; // RQ23
                end else if (mem_ack) begin
                    mem_req <= 1'b0;
                    if (!(mc_nz && mp_nz)) zero_bal <= 1'b1; // RQ17
                    busy <= 1'b0;
                    state <= S_IDLE;
                end
                S_DSCAN: if (!mem_req) begin
                    {mem_req, mem_we, mem_addr} <= {2'b10, a_ptr};
                end else if (mem_ack) begin
                    mem_req <= 1'b0;
                    a_ptr <= a_ptr - AW'(1);
                    nz <= nz || (digit(mem_rdata) != 4'h0);
                    if (mem_rmark) begin
                        busy <= 1'b0;
                        state <= S_IDLE;
                    end
                end
            endcase
        end
    end

    a_mem_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("memory request changed before ack");
    a_ovf_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RQ18
        ovf && !test_clr |=> ovf)
        else $error("overflow lost without condition test");
    a_ovf_clear: assert property (@(posedge aclk) disable iff (!aresetn) // RQ18
        test_clr && !ovf_set |=> !ovf)
        else $error("condition test did not clear overflow");
    a_zero_start: assert property (@(posedge aclk) disable iff (!aresetn) // RQ16
        state == S_IDLE && start && (start_op == OP_DEC_ADD || start_op == OP_DEC_SUB)
        |=> zero_bal && busy)
        else $error("zero balance not set at start");
    a_bin_no_ovf: assert property (@(posedge aclk) disable iff (!aresetn) // RQ7
        busy && (op == OP_BIN_ADD || op == OP_BIN_SUB) |-> !ovf_set)
        else $error("binary operation raised overflow");
    a_comp_no_ovf: assert property (@(posedge aclk) disable iff (!aresetn) // RQ15
        state == S_WRB && !first && comp |-> !ovf_set)
        else $error("complement add raised overflow");
    a_mul_units: assert property (@(posedge aclk) disable iff (!aresetn) // RQ22
        state == S_MRDM && first && mem_req |-> mem_addr == b_start - na - AW'(1))
        else $error("multiplier units address wrong");
    a_zone_clear: assert property (@(posedge aclk) disable iff (!aresetn) // RQ10
        state == S_WRB && mem_req && mem_we && !first && op != OP_BIN_ADD
        && op != OP_BIN_SUB |-> mem_wdata[5:4] == `ZONE_NONE)
        else $error("nonunits zone not cleared");
    a_rc_sign: assert property (@(posedge aclk) disable iff (!aresetn) // RQ13
        state == S_RCWR && mem_req && first
        |-> mem_wdata[5:4] == (sb ? `ZONE_PLUS : `ZONE_MINUS))
        else $error("recomplement sign not inverted");
    a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
endmodule // char_serial_arith_unit
`default_nettype wire

// >>> test/mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module mem_model #(
    parameter int AW = 16
) (
    // Clock
    input wire logic aclk,
    // Character port
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [AW-1:0] mem_addr,
    input wire logic [5:0] mem_wdata,
    output logic [5:0] mem_rdata,
    output logic mem_rmark,
    output logic mem_ack
);
    logic [5:0] mem [0:511];
    logic mark [0:511];
    int slow = 0, cnt = 0;
    initial {mem_ack, mem_rmark, mem_rdata} = 8'h00;
    // Ack after slow idle cycles; data toggles outside ack
    always @(posedge aclk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        mem_rmark <= ~mem_rmark;
        if (mem_req && !mem_ack && cnt < slow) cnt <= cnt + 1;
        else if (mem_req && !mem_ack) begin
            cnt <= 0;
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr[8:0]];
            mem_rmark <= mark[mem_addr[8:0]];
            if (mem_we) mem[mem_addr[8:0]] <= mem_wdata;
        end
    end
endmodule // mem_model
`default_nettype wire

// >>> test/char_serial_arith_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "char_arith_consts.svh"
module char_serial_arith_unit_tb;
    import char_arith_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, mem_req, mem_we, mem_rmark, mem_ack;
    logic [1:0] bresp, rresp;
    logic [15:0] mem_addr;
    logic [5:0] mem_wdata, mem_rdata;
    logic [1:0] zs [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
    int bad_count = 0, compares = 0;
    bit ovf_ind = 0, zero_ind = 0;
    always #50 aclk = ~aclk;
    char_serial_arith_unit u_char_serial_arith_unit (.aclk, .aresetn, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .mem_req, .mem_we, .mem_addr, .mem_wdata,
        .mem_rdata, .mem_rmark, .mem_ack);
    mem_model u_mem_model (.aclk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
        .mem_rmark, .mem_ack);
    task automatic print_verdict;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic axi_wr(logic [7:0] a, logic [31:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        check("bresp", bresp, `RESP_OKAY);
        bready <= 0;
    endtask
    task automatic axi_rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask
    task automatic run(int op, int aa, int ba);
        logic [31:0] s;
        logic [1:0] r;
        u_mem_model.slow = $urandom % 3;
        axi_wr(`REG_A_ADDR, aa);
        axi_wr(`REG_B_ADDR, ba);
        axi_wr(`REG_CTRL, 32'(op));
        do axi_rd(`REG_STATUS, s, r); while (s[`STAT_BUSY_BIT] !== 1'b0);
        check("overflow", s[`STAT_OVF_BIT], ovf_ind);
        check("zero balance", s[`STAT_ZERO_BIT], zero_ind);
    endtask
    task automatic put(int at, int len, int m, logic [1:0] z, int base);
        for (int i = 0; i < len; i++) begin
            u_mem_model.mem[at-i] = 6'(m % base);
            u_mem_model.mark[at-i] = (i == len - 1);
            m = m / base;
        end
        if (base == 10) u_mem_model.mem[at][5:4] = z;
    endtask
    task automatic chk(int at, int len, int m, logic [1:0] z, int base);
        logic [5:0] e;
        for (int i = 0; i < len; i++) begin
            e = 6'(m % base);
            if (base == 10) e[5:4] = (i == 0) ? z : 2'b00;
            check("field char", u_mem_model.mem[at-i], e);
            m = m / base;
        end
    endtask
    initial begin
        repeat (90000) @(posedge aclk);
        bad_count++;
        print_verdict();
    end
    initial begin
        int a, b, m, ma, mb;
        logic [1:0] za, zb, z;
        logic [31:0] s;
        logic [1:0] r;
        bit sub, sa, sb;
        void'($urandom(32'h3bac37eb));
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        // Binary add and subtract
        put(295, 2, 73, 0, 64);
        put(300, 2, 87, 0, 64);
        u_mem_model.mem[298] = 6'h2a;
        run(OP_BIN_SUB, 295, 300);
        chk(300, 2, 14, 0, 64);
        check("beyond B", u_mem_model.mem[298], 6'h2a);
        for (int k = 0; k < 6; k++) begin
            a = $urandom % (1 << (6 * (k % 3 + 1)));
            b = $urandom % 4096;
            put(10, k % 3 + 1, a, 0, 64);
            put(20, 2, b, 0, 64);
            u_mem_model.mem[18] = 6'h15;
            u_mem_model.mark[18] = 0;
            run(k < 3 ? OP_BIN_ADD : OP_BIN_SUB, 10, 20);
            m = k < 3 ? (b + a % 4096) % 4096 : (b - a % 4096 + 4096) % 4096;
            chk(20, 2, m, 0, 64);
            check("beyond B", u_mem_model.mem[18], 6'h15);
        end
        // Decimal add and subtract
        for (int k = 0; k < 12; k++) begin
            sub = (k % 2 == 0);
            ma = $urandom % 1000;
            mb = $urandom % 1000;
            za = zs[$urandom % 4];
            zb = zs[$urandom % 4];
            if (k == 0) begin
                ma = mb;
                za = zb;
            end
            sa = (za == 2'b10) ^ sub;
            sb = (zb == 2'b10);
            if (sa == sb) begin
                m = ma + mb;
                if (m > 999) ovf_ind = 1;
                m = m % 1000;
                z = zb;
            end else begin
                m = ma > mb ? ma - mb : mb - ma;
                z = ((ma > mb) != sb) ? `ZONE_MINUS : `ZONE_PLUS;
            end
            zero_ind = (m == 0);
            put(10, 3, ma, za, 10);
            put(20, 3, mb, zb, 10);
            run(sub ? OP_DEC_SUB : OP_DEC_ADD, 10, 20);
            chk(20, 3, m, z, 10);
            if (k % 3 == 2) begin
                axi_wr(`REG_TEST, 32'h1);
                ovf_ind = 0;
            end
        end
        // Multiply
        for (int k = 0; k < 4; k++) begin
            ma = k == 0 ? 0 : $urandom % 100;
            mb = $urandom % 100;
            za = zs[$urandom % 4];
            zb = zs[$urandom % 4];
            put(20, 2, ma, za, 10);
            put(37, 2, mb, zb, 10);
            for (int i = 38; i <= 40; i++) begin
                u_mem_model.mem[i] = 6'(i);
                u_mem_model.mark[i] = 0;
            end
            if (ma * mb == 0) zero_ind = 1;
            z = ((za == 2'b10) != (zb == 2'b10)) ? `ZONE_MINUS : `ZONE_PLUS;
            run(OP_DEC_MUL, 20, 40);
            chk(40, 5, ma * mb, z, 10);
        end
        // Zero divisor and condition test
        put(20, 2, 0, `ZONE_PLUS, 10);
        ovf_ind = 1;
        run(OP_DEC_DIV, 20, 40);
        axi_wr(`REG_TEST, 32'h1);
        ovf_ind = 0;
        axi_rd(`REG_STATUS, s, r);
        check("status", s[2:0], {zero_ind, 2'b00});
        axi_rd(8'h14, s, r);
        check("unmapped", r, `RESP_SLVERR);
        print_verdict();
    end
endmodule // char_serial_arith_unit_tb
`default_nettype wire
